// File: core/exposure_control.v
// Purpose: exposure sequencer with wishbone registers, internal/external timing,
//          interleaved dual exposure and piecewise-linear knee timing
// Assumes: pins synchronous to clk_i; external pins are single-clock-wide or longer pulses
// Notes: wishbone ack comes two cycles after the request is presented
`timescale 1ns/1ps
`include "exposure_defines.vh"
module exposure_control (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [9:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// exposure pins
	input wire exposure_start_a_i,
	input wire exposure_start_b_i,
	input wire frame_request_i,
	// sensor sequencer outputs
	output reg expose_even_o,
	output reg expose_odd_o,
	output reg fot_o,
	output reg first_clip_level_o,
	output reg second_clip_level_o,
	output reg bayer_pairs_o
);
	// ====================================================================
	// states
	localparam [4:0] S_IDLE = 5'b00001;
	localparam [4:0] S_EXPOSE = 5'b00010;
	localparam [4:0] S_KNEE1 = 5'b00100;
	localparam [4:0] S_KNEE2 = 5'b01000;
	localparam [4:0] S_OVH = 5'b10000;

	// ====================================================================
	// registers
	reg [7:0] mode_ff;
	reg [7:0] mono_ff;
	reg [23:0] exp_ff;
	reg [23:0] odd_ff;
	reg [23:0] knee1_ff;
	reg [23:0] knee2_ff;
	reg [1:0] slopes_ff;
	reg [7:0] overhead_ff;
	reg [4:0] state_ff;
	reg [4:0] nxt_state;
	reg ext_a_ff;
	reg ext_b_ff;
	reg prev_a_ff;
	reg prev_b_ff;
	reg prev_req_ff;
	reg ack_pend_ff;
	reg [7:0] rd_sel_ff;
	reg [3:0] scratch_hit_ff;
	wire [7:0] scratch_rd;
	wire [7:0] idx;
	wire req;
	wire wr;
	wire rise_a;
	wire rise_b;
	wire rise_req;
	wire even_busy;
	wire odd_busy;
	wire ovh_busy;
	wire int_open;
	reg even_load;
	reg odd_load;
	reg ovh_load;
	reg [23:0] even_units;

	assign idx = adr_i[9:2];
	assign req = cyc_i & stb_i & ~ack_o;
	assign wr = req & we_i & sel_i[0];
	assign rise_a = exposure_start_a_i & ~prev_a_ff;
	assign rise_b = exposure_start_b_i & ~prev_b_ff;
	assign rise_req = frame_request_i & ~prev_req_ff;
	// rows stay open across the reload cycle between main exposure and knees
	assign int_open = even_busy || (even_load && state_ff == S_EXPOSE) || state_ff == S_KNEE1
		|| state_ff == S_KNEE2;

	// ====================================================================
	// decode helpers
	function is_mapped;
		input [7:0] i;
		begin
			case (i)
				`IDX_COLOUR_TYPE, `IDX_MODE_CTRL, `IDX_EXP_B0, `IDX_EXP_B1, `IDX_EXP_B2,
				`IDX_KNEE1_B0, `IDX_KNEE1_B1, `IDX_KNEE1_B2, `IDX_KNEE2_B0,
				`IDX_KNEE2_B1, `IDX_KNEE2_B2, `IDX_SLOPES, `IDX_ODD_B0,
				`IDX_ODD_B1, `IDX_ODD_B2, `IDX_OVERHEAD, `IDX_STATUS: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// byte lane of a 24-bit count, low index is least significant
	function [23:0] put_byte;
		input [23:0] old;
		input [1:0] lane;
		input [7:0] b;
		begin
			case (lane)
				2'd0: put_byte = {old[23:8], b};
				2'd1: put_byte = {old[23:16], b, old[7:0]};
				default: put_byte = {b, old[15:0]};
			endcase
		end
	endfunction

	// scratch memory for the unused upper bits region is not needed; it holds
	// spare bytes in the 0x40..0x4f index window except the overhead register
	exposure_regfile u_scratch (
		.clk_i(clk_i),
		.wr_en_i(wr && idx[7:4] == 4'h4 && idx != `IDX_OVERHEAD),
		.wr_addr_i(idx[3:0]),
		.wr_data_i(dat_i[7:0]),
		.rd_addr_i(idx[3:0]),
		.rd_data_o(scratch_rd)
	);

	// ====================================================================
	// register writes
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode_ff <= `RST_MODE;
			mono_ff <= `RST_MONO;
			exp_ff <= `RST_EXP_COUNT;
			odd_ff <= `RST_EXP_COUNT;
			knee1_ff <= `RST_KNEE_COUNT;
			knee2_ff <= `RST_KNEE_COUNT;
			slopes_ff <= `RST_SLOPES;
			overhead_ff <= `RST_OVERHEAD;
		end else if (wr) begin
			case (idx)
				`IDX_COLOUR_TYPE: mono_ff <= {7'h00, dat_i[`MONO_BIT]};
				`IDX_MODE_CTRL: mode_ff <= {6'h00, dat_i[1:0]};
				// count bytes by lane, low index least significant
				`IDX_EXP_B0, `IDX_EXP_B1, `IDX_EXP_B2:
					exp_ff <= put_byte(exp_ff, idx[1:0] - 2'd2, dat_i[7:0]);
				`IDX_ODD_B0, `IDX_ODD_B1, `IDX_ODD_B2:
					odd_ff <= put_byte(odd_ff, idx[1:0], dat_i[7:0]);
				`IDX_KNEE1_B0, `IDX_KNEE1_B1, `IDX_KNEE1_B2:
					knee1_ff <= put_byte(knee1_ff, idx[1:0], dat_i[7:0]);
				`IDX_KNEE2_B0, `IDX_KNEE2_B1, `IDX_KNEE2_B2:
					knee2_ff <= put_byte(knee2_ff, idx[1:0] - 2'd3, dat_i[7:0]);
				`IDX_SLOPES: begin
					// zero is clamped to one slope
					slopes_ff <= (dat_i[1:0] == 2'd0) ? 2'd1 : dat_i[1:0];
				end
				`IDX_OVERHEAD: overhead_ff <= dat_i[7:0];
				default: begin
				end
			endcase
		end
	end

	// ====================================================================
	// wishbone answer: two cycle latency, unmapped reads zero
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			ack_pend_ff <= 1'b0;
			dat_o <= 32'h0;
			rd_sel_ff <= 8'h00;
			scratch_hit_ff <= 4'h0;
		end else begin
			ack_pend_ff <= req & ~ack_pend_ff;
			ack_o <= ack_pend_ff;
			rd_sel_ff <= idx;
			scratch_hit_ff <= {3'h0, idx[7:4] == 4'h4 && idx != `IDX_OVERHEAD};
			if (ack_pend_ff) begin
				if (scratch_hit_ff[0]) begin
					dat_o <= {24'h0, scratch_rd};
				end else if (!is_mapped(rd_sel_ff)) begin
					dat_o <= 32'h0;
				end else begin
					case (rd_sel_ff)
						`IDX_COLOUR_TYPE: dat_o <= {24'h0, mono_ff};
						`IDX_MODE_CTRL: dat_o <= {24'h0, mode_ff};
						`IDX_EXP_B0: dat_o <= {24'h0, exp_ff[7:0]};
						`IDX_EXP_B1: dat_o <= {24'h0, exp_ff[15:8]};
						`IDX_EXP_B2: dat_o <= {24'h0, exp_ff[23:16]};
						`IDX_ODD_B0: dat_o <= {24'h0, odd_ff[7:0]};
						`IDX_ODD_B1: dat_o <= {24'h0, odd_ff[15:8]};
						`IDX_ODD_B2: dat_o <= {24'h0, odd_ff[23:16]};
						`IDX_KNEE1_B0: dat_o <= {24'h0, knee1_ff[7:0]};
						`IDX_KNEE1_B1: dat_o <= {24'h0, knee1_ff[15:8]};
						`IDX_KNEE1_B2: dat_o <= {24'h0, knee1_ff[23:16]};
						`IDX_KNEE2_B0: dat_o <= {24'h0, knee2_ff[7:0]};
						`IDX_KNEE2_B1: dat_o <= {24'h0, knee2_ff[15:8]};
						`IDX_KNEE2_B2: dat_o <= {24'h0, knee2_ff[23:16]};
						`IDX_SLOPES: dat_o <= {30'h0, slopes_ff};
						`IDX_OVERHEAD: dat_o <= {24'h0, overhead_ff};
						// live sequencer status
						`IDX_STATUS: dat_o <= {24'h0, fot_o, second_clip_level_o,
							first_clip_level_o, state_ff};
						default: dat_o <= 32'h0;
					endcase
				end
			end
		end
	end

	// ====================================================================
	// timers: even/main, odd, overhead
	exposure_timer u_even (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(even_load),
		.units_i(even_units),
		.overhead_i(overhead_ff),
		.busy_o(even_busy),
		.done_o()
	);

	exposure_timer u_odd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(odd_load),
		.units_i(odd_ff),
		.overhead_i(overhead_ff),
		.busy_o(odd_busy),
		.done_o()
	);

	exposure_timer u_ovh (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(ovh_load),
		.units_i(24'h0),
		.overhead_i(overhead_ff),
		.busy_o(ovh_busy),
		.done_o()
	);

	// ====================================================================
	// sequencer next state
	always @* begin
		nxt_state = state_ff;
		even_load = 1'b0;
		odd_load = 1'b0;
		ovh_load = 1'b0;
		even_units = exp_ff;
		case (state_ff)
			S_IDLE: begin
				if (!mode_ff[`MODE_EXT_BIT] && rise_req) begin
					// internal: count from the programmed value
					even_load = 1'b1;
					odd_load = mode_ff[`MODE_DUAL_BIT];
					nxt_state = S_EXPOSE;
				end else if (mode_ff[`MODE_EXT_BIT] && (rise_a || rise_b)) begin
					nxt_state = S_EXPOSE;
				end
			end
			S_EXPOSE: begin
				if (mode_ff[`MODE_EXT_BIT]) begin
					// even a single clock before the trigger is a valid gap
					if (rise_req) begin
						ovh_load = 1'b1;
						nxt_state = S_OVH;
					end
				end else if (!even_busy && !odd_busy && !even_load) begin
					if (slopes_ff >= 2'd2 && !mode_ff[`MODE_DUAL_BIT]) begin
						even_units = knee1_ff;
						even_load = 1'b1;
						nxt_state = S_KNEE1;
					end else begin
						nxt_state = S_OVH;
						ovh_load = 1'b0;
					end
				end
			end
			S_KNEE1: begin
				if (!even_busy && !even_load) begin
					if (slopes_ff == 2'd3) begin
						even_units = knee2_ff;
						even_load = 1'b1;
						nxt_state = S_KNEE2;
					end else begin
						nxt_state = S_OVH;
					end
				end
			end
			S_KNEE2: begin
				if (!even_busy) begin
					nxt_state = S_OVH;
				end
			end
			S_OVH: begin
				if (!ovh_busy && !ovh_load) begin
					nxt_state = S_IDLE;
				end
			end
			default: nxt_state = S_IDLE;
		endcase
	end

	// ====================================================================
	// state, pin history and outputs
	always @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= S_IDLE;
			prev_a_ff <= 1'b0;
			prev_b_ff <= 1'b0;
			prev_req_ff <= 1'b0;
			ext_a_ff <= 1'b0;
			ext_b_ff <= 1'b0;
			expose_even_o <= 1'b0;
			expose_odd_o <= 1'b0;
			fot_o <= 1'b0;
			first_clip_level_o <= 1'b0;
			second_clip_level_o <= 1'b0;
			bayer_pairs_o <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			prev_a_ff <= exposure_start_a_i;
			prev_b_ff <= exposure_start_b_i;
			prev_req_ff <= frame_request_i;
			// external dual: pin a opens even rows, pin b odd rows
			if (state_ff == S_IDLE || state_ff == S_OVH) begin
				ext_a_ff <= 1'b0;
				ext_b_ff <= 1'b0;
			end
			if (mode_ff[`MODE_EXT_BIT] && (state_ff == S_IDLE || state_ff == S_EXPOSE)) begin
				if (rise_a) begin
					ext_a_ff <= 1'b1;
				end
				if (rise_b && mode_ff[`MODE_DUAL_BIT]) begin
					ext_b_ff <= 1'b1;
				end
			end
			if (mode_ff[`MODE_EXT_BIT]) begin
				// tail timer, not the state, so the total is gap plus tail exactly
				expose_even_o <= ext_a_ff || ovh_busy;
				expose_odd_o <= mode_ff[`MODE_DUAL_BIT] ? (ext_b_ff || ovh_busy)
					: (ext_a_ff || ovh_busy);
			end else begin
				expose_even_o <= int_open;
				expose_odd_o <= mode_ff[`MODE_DUAL_BIT] ? odd_busy : int_open;
			end
			// overhead tail in external mode
			fot_o <= ovh_busy;
			// clip only while the knee timer runs, not in the reload cycle
			first_clip_level_o <= (state_ff == S_KNEE1) && even_busy;
			second_clip_level_o <= (state_ff == S_KNEE2) && even_busy;
			// colour arrays interleave in row pairs
			bayer_pairs_o <= mode_ff[`MODE_DUAL_BIT] & ~mono_ff[`MONO_BIT];
		end
	end
endmodule // exposure_control

// File: core/exposure_defines.vh
// Purpose: constants for the exposure control block (offsets, fields, resets, timing)
// Assumes: 200 MHz clock, classic wishbone with 32-bit data, one register per word
// Notes: register byte address is four times the register index
// Overview of operation
// - mode bit 0 selects programmed count, 1 selects external pulse gap; resets 0
// - external exposure runs from start pin a rise to readout trigger rise
// - internal exposure lasts 129 clocks times (0.43 overhead plus count)
// - external mode appends 129 clocks times 0.43 overhead after the measured gap
// - a gap of a single clock between start edge and trigger is accepted
// - dual exposure bit disables interleave at 0, its reset value, enables at 1
// - dual internal mode times even rows from primary count, default 1088
// - dual internal mode times odd rows from second count, default 1088
// - dual external mode: pin a times even lines, pin b odd lines
// - greyscale bit resets to 1; 0 selects colour, with bayer-pair interleave only while the dual exposure bit is 1
// - piecewise mode changes the clip level at most twice per exposure
// - bright pixels held at clip levels for programmed durations twice in a row
// - slope count selects one to three slopes, default one
// - knee durations are 24-bit counts defaulting to 1, same 129 scaling
`ifndef EXPOSURE_DEFINES_VH
`define EXPOSURE_DEFINES_VH

// register indexes
`define IDX_COLOUR_TYPE 8'h27
`define IDX_MODE_CTRL 8'h29
`define IDX_EXP_B0 8'h2a
`define IDX_EXP_B1 8'h2b
`define IDX_EXP_B2 8'h2c
`define IDX_KNEE1_B0 8'h30
`define IDX_KNEE1_B1 8'h31
`define IDX_KNEE1_B2 8'h32
`define IDX_KNEE2_B0 8'h33
`define IDX_KNEE2_B1 8'h34
`define IDX_KNEE2_B2 8'h35
`define IDX_SLOPES 8'h36
`define IDX_ODD_B0 8'h38
`define IDX_ODD_B1 8'h39
`define IDX_ODD_B2 8'h3a
`define IDX_OVERHEAD 8'h49
`define IDX_STATUS 8'h60

// field positions
`define MODE_EXT_BIT 0
`define MODE_DUAL_BIT 1
`define MONO_BIT 0

// reset values
`define RST_MODE 8'h00
`define RST_MONO 8'h01
`define RST_EXP_COUNT 24'h000440
`define RST_KNEE_COUNT 24'h000001
`define RST_SLOPES 2'h1
`define RST_OVERHEAD 8'h0a

// timing: one count unit is 129 clocks; overhead weight 0.43 = 43/100
`define UNIT_CLOCKS 8'h81
`define OVH_NUM 8'h2b
`define OVH_DEN 8'h64

`endif

// File: core/exposure_regfile.v
// Purpose: small byte-wide register memory with registered read data
// Assumes: synchronous write, one write port, one read port
// Notes: reset loads nothing; the control block keeps its own reset copies
`timescale 1ns/1ps
module exposure_regfile (
	// clock
	input wire clk_i,
	// write port
	input wire wr_en_i,
	input wire [3:0] wr_addr_i,
	input wire [7:0] wr_data_i,
	// read port
	input wire [3:0] rd_addr_i,
	output reg [7:0] rd_data_o
);
	reg [7:0] mem [0:15];

	// write then registered read
	always @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule // exposure_regfile

// File: core/exposure_timer.v
// Purpose: counts out 129 clocks per count unit, with a fractional overhead part
// Assumes: load pulses only while idle
// Notes: total = 129*units + floor(129*0.43*overhead) clocks
`timescale 1ns/1ps
`include "exposure_defines.vh"
module exposure_timer (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// control
	input wire load_i,
	input wire [23:0] units_i,
	input wire [7:0] overhead_i,
	// status
	output reg busy_o,
	output reg done_o
);
	reg [39:0] left_ff;
	reg [39:0] total;

	// clocks for the units and the overhead share
	always @* begin
		total = {16'h0000, units_i} * {32'h0, `UNIT_CLOCKS}
			+ ({32'h0, overhead_i} * {32'h0, `UNIT_CLOCKS} * {32'h0, `OVH_NUM})
			/ {32'h0, `OVH_DEN};
	end

	// down counter, done pulses as it expires
	always @(posedge clk_i) begin
		if (rst_i) begin
			left_ff <= 40'h0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (load_i) begin
				left_ff <= (total == 40'h0) ? 40'h1 : total;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (left_ff == 40'h1) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end
				left_ff <= left_ff - 40'h1;
			end
		end
	end
endmodule // exposure_timer

// File: tb/exposure_checker.sv
// Purpose: port-level timing checks for exposure_control
// Assumes: one clock, synchronous active-high reset
// Notes: sees only top ports, so register state is judged through outputs
`timescale 1ns/1ps
module exposure_checker (
	// clock and reset
	input wire clk_i,
	input wire rst_i,
	// bus
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire ack_o,
	// pins
	input wire exposure_start_a_i,
	input wire frame_request_i,
	input wire expose_even_o,
	input wire expose_odd_o,
	input wire fot_o,
	input wire first_clip_level_o,
	input wire second_clip_level_o,
	input wire bayer_pairs_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========
	// bus answer
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_ack_late: assert property (ack_o |-> $past(cyc_i && stb_i) && $past(cyc_i && stb_i, 2))
		else $error("ack without a standing request");
	// ==========
	// sequencer outputs; reset check must not be disabled by reset itself
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=>
		!(ack_o || expose_even_o || expose_odd_o || fot_o || bayer_pairs_o))
		else $error("outputs active after reset");
	chk_open_cause: assert property ($rose(expose_even_o) |->
		$past(frame_request_i || exposure_start_a_i))
		else $error("even exposure opened with no pin");
	chk_clip_apart: assert property (!(first_clip_level_o && second_clip_level_o))
		else $error("both clip levels at once");
	chk_clip_chain: assert property ($rose(second_clip_level_o) |->
		$past(first_clip_level_o, 2))
		else $error("second clip without first");
	chk_clip_single: assert property (first_clip_level_o |-> expose_odd_o == expose_even_o)
		else $error("clip during interleave");
	chk_bayer_write: assert property ($changed(bayer_pairs_o) |->
		$past(cyc_i && stb_i && we_i) || $past(cyc_i && stb_i && we_i, 2) ||
		$past(cyc_i && stb_i && we_i, 3))
		else $error("bayer flag moved without a write");
endmodule // exposure_checker

bind exposure_control exposure_checker exposure_checker_i (.clk_i(clk_i), .rst_i(rst_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .ack_o(ack_o),
	.exposure_start_a_i(exposure_start_a_i), .frame_request_i(frame_request_i),
	.expose_even_o(expose_even_o), .expose_odd_o(expose_odd_o), .fot_o(fot_o),
	.first_clip_level_o(first_clip_level_o), .second_clip_level_o(second_clip_level_o),
	.bayer_pairs_o(bayer_pairs_o));

// File: tb/camera_ctrl_model.sv
// Purpose: camera controller driving exposure and frame-request pins
// Assumes: pins idle low, changed just after a rising edge
// Notes: pins held a few cycles so edge detectors see them
`timescale 1ns/1ps
module camera_ctrl_model (
	// clock
	input wire clk_i,
	// controller pins
	output reg start_a_o,
	output reg start_b_o,
	output reg request_o
);
	// idle pins from time zero
	initial begin
		start_a_o = 1'b0;
		start_b_o = 1'b0;
		request_o = 1'b0;
	end
	// a opens ta cycles before request, b opens tb before; zero skips a pin
	task frame(input int ta, input int tb);
		int k;
		for (k = 0; k <= ta + 4; k++) begin
			@(posedge clk_i);
			if (k == 0 && ta > 0) start_a_o <= 1'b1;
			if (tb > 0 && k == ta - tb) start_b_o <= 1'b1;
			if (k == ta) request_o <= 1'b1;
		end
		@(posedge clk_i);
		start_a_o <= 1'b0;
		start_b_o <= 1'b0;
		request_o <= 1'b0;
	endtask
endmodule // camera_ctrl_model

// File: tb/exposure_control_tb.sv
// Purpose: self-checking bench for exposure_control
// Assumes: overhead programmed to 5 before any timed frame
// Notes: durations counted as sampled-high clock edges
`timescale 1ns/1ps
`include "exposure_defines.vh"
module exposure_control_tb;
	localparam int TAIL = 129 * 43 * 5 / 100;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [9:0] adr_i = 10'h000;
	logic [3:0] sel_i = 4'h0;
	logic [31:0] dat_i = 32'h0;
	wire [31:0] dat_o;
	wire ack_o, sa, sb, rq, ev, od, fot, c1, c2, bay;
	int n_fail = 0, num_checks = 0;
	// ==========
	// clock, design and partner
	always #2.5 clk_i = ~clk_i;
	exposure_control exposure_control_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .exposure_start_a_i(sa), .exposure_start_b_i(sb),
		.frame_request_i(rq), .expose_even_o(ev), .expose_odd_o(od), .fot_o(fot),
		.first_clip_level_o(c1), .second_clip_level_o(c2), .bayer_pairs_o(bay));
	camera_ctrl_model camera_ctrl_model_i (.clk_i(clk_i), .start_a_o(sa), .start_b_o(sb),
		.request_o(rq));
	// ==========
	// shared tasks
	task check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// classic cycle: held until ack is sampled, released on that edge
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s,
		output logic [31:0] q);
		int t;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, s};
		adr_i <= {idx, 2'b00};
		dat_i <= {24'h0, d};
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 64);
		if (t >= 64) n_fail++;
		q = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	task wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] q;
		wb(1'b1, idx, d, 4'h1, q);
	endtask
	task rdc(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, idx, 8'h00, 4'h1, q);
		check(q, exp);
	endtask
	function logic sig(input int s);
		case (s)
			0: sig = ev;
			1: sig = od;
			2: sig = fot;
			3: sig = c1;
			default: sig = c2;
		endcase
	endfunction
	// waits bounded for a rise, then counts high cycles
	task automatic hi_len(input int s, output int n);
		int t;
		t = 0;
		n = 0;
		while (sig(s) !== 1'b1 && t < 2000) begin
			@(posedge clk_i);
			t++;
		end
		while (sig(s) === 1'b1 && n < 40000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task frame_len(input int ta, input int tb, input int s0, input int s1,
		output int n0, output int n1);
		fork
			camera_ctrl_model_i.frame(ta, tb);
			hi_len(s0, n0);
			hi_len(s1, n1);
		join
	endtask
	// ==========
	// scenarios
	task t_reset_vals;
		rdc(`IDX_MODE_CTRL, 32'h0);
		rdc(`IDX_COLOUR_TYPE, 32'h1);
		rdc(`IDX_EXP_B0, 32'h40);
		rdc(`IDX_EXP_B1, 32'h04);
		rdc(`IDX_ODD_B1, 32'h04);
		rdc(`IDX_KNEE1_B0, 32'h01);
		rdc(`IDX_KNEE2_B2, 32'h00);
		rdc(`IDX_SLOPES, 32'h1);
		rdc(`IDX_OVERHEAD, 32'h0a);
		wr(8'h40, 8'h5a);
		rdc(8'h40, 32'h5a);
		rdc(8'h7f, 32'h0);
		check(bay, 1'b0);
	endtask
	task t_internal;
		logic [31:0] q;
		int n, m;
		wr(`IDX_OVERHEAD, 8'h05);
		wr(`IDX_EXP_B0, 8'h01);
		wr(`IDX_EXP_B1, 8'h01);
		wb(1'b1, `IDX_EXP_B2, 8'h77, 4'h0, q);
		rdc(`IDX_EXP_B2, 32'h0);
		frame_len(0, 0, 0, 2, n, m);
		check(n, 129 * 257 + TAIL);
		wr(`IDX_EXP_B1, 8'h00);
		frame_len(0, 0, 0, 2, n, m);
		check(n, 129 + TAIL);
	endtask
	task t_slopes;
		int n1, n2;
		wr(`IDX_SLOPES, 8'h00);
		rdc(`IDX_SLOPES, 32'h1);
		wr(`IDX_SLOPES, 8'h03);
		wr(`IDX_KNEE2_B0, 8'h02);
		frame_len(0, 0, 3, 4, n1, n2);
		check(n1, 129 + TAIL);
		check(n2, 258 + TAIL);
		wr(`IDX_SLOPES, 8'h02);
		frame_len(0, 0, 3, 4, n1, n2);
		check(n1, 129 + TAIL);
		check(n2, 0);
		wr(`IDX_SLOPES, 8'h01);
	endtask
	task t_dual_int;
		int ne, no;
		wr(`IDX_MODE_CTRL, 8'h02);
		wr(`IDX_ODD_B0, 8'h02);
		wr(`IDX_ODD_B1, 8'h00);
		frame_len(0, 0, 0, 1, ne, no);
		check(ne, 129 + TAIL);
		check(no, 258 + TAIL);
		wr(`IDX_COLOUR_TYPE, 8'h00);
		repeat (3) @(posedge clk_i);
		check(bay, 1'b1);
		wr(`IDX_MODE_CTRL, 8'h00);
		repeat (3) @(posedge clk_i);
		check(bay, 1'b0);
	endtask
	task t_external;
		int ne, nf, g;
		wr(`IDX_MODE_CTRL, 8'h01);
		for (g = 1; g <= 21; g += 20) begin
			frame_len(g, 0, 0, 2, ne, nf);
			check(ne, g + TAIL);
			check(nf, TAIL);
		end
		wr(`IDX_MODE_CTRL, 8'h03);
		frame_len(30, 10, 0, 1, ne, nf);
		check(ne, 30 + TAIL);
		check(nf, 10 + TAIL);
	endtask
	// ==========
	// verdict, main sequence and watchdog
	task finish_test;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_vals;
		t_internal;
		t_slopes;
		t_dual_int;
		t_external;
		finish_test;
	end
	// whole run is about 40k cycles; this only cuts a hang
	initial begin
		repeat (80000) @(posedge clk_i);
		n_fail++;
		finish_test;
	end
endmodule // exposure_control_tb
